// ===== sscp_port.v
// serial command port: SPI mode 3 or I2C slave in front of the sensor core
`timescale 1ns/1ns
`include "sscp_defines.vh"
module sscp_port #(
   parameter NVM_BUSY_CYC = `SSCP_NVM_BUSY_CYC
) (
   input wire mclk,
   input wire reset_n,
   input wire iface_select,
   input wire chip_select_low,
   input wire sclk,
   input wire sdi,
   output reg sdo,
   output reg sdo_oe_n,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe_n,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n,
   input wire [23:0] result_data,
   input wire [7:0] status_data,
   input wire nvm_done,
   input wire [7:0] nvm_data,
   output reg cmd_valid,
   output reg [7:0] cmd_code,
   output reg go_shutdown,
   output reg go_idle,
   output reg start_measure,
   output reg [1:0] measure_setting,
   output reg nvm_req,
   output reg [7:0] nvm_addr
);
   localparam [6:0] S_CMD = 7'h01, S_ACK = 7'h02, S_DATA = 7'h04, S_ADDR = 7'h08;
   localparam [6:0] S_POLL = 7'h10, S_NVMD = 7'h20, S_DONE = 7'h40;
   localparam [6:0] I_IDLE = 7'h01, I_ADDR = 7'h02, I_CMD = 7'h04, I_MADDR = 7'h08;
   localparam [6:0] I_WRX = 7'h10, I_RD = 7'h20, I_SKIP = 7'h40;

   // command class decode, shared by both links
   function [2:0] cmd_class;
      input [7:0] c;
      begin
         case (c)
            `SSCP_CMD_RESET, `SSCP_CMD_IDLE, `SSCP_CMD_MEAS1,
            `SSCP_CMD_MEAS2, `SSCP_CMD_MEAS3, `SSCP_CMD_MEAS4: cmd_class = `SSCP_CL_OP;
            `SSCP_CMD_PRESS: cmd_class = `SSCP_CL_RES;
            `SSCP_CMD_STATUS: cmd_class = `SSCP_CL_STAT;
            `SSCP_CMD_NVM: cmd_class = `SSCP_CL_NVM;
            default: cmd_class = `SSCP_CL_OTHER;
         endcase
      end
   endfunction

   function nvm_addr_ok;
      input [7:0] a;
      begin
         nvm_addr_ok = (a == `SSCP_NVM_ADDR_A) || (a == `SSCP_NVM_ADDR_B);
      end
   endfunction

   wire [5:0] pins_q;
   sscp_sync #(.W(6), .RST_VAL(6'h3f)) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .d({iface_select, chip_select_low, sclk, sdi, scl_in, sda_in}),
      .q(pins_q)
   );
   wire sel_q = pins_q[5];
   wire cs_q = pins_q[4];
   wire sclk_q = pins_q[3];
   wire sdi_q = pins_q[2];
   wire scl_q = pins_q[1];
   wire sda_q = pins_q[0];

   reg cs_d_ff, sclk_d_ff, scl_d_ff, sda_d_ff;
   reg [6:0] spi_st_ff, i2c_st_ff;
   reg [2:0] spi_cnt_ff;
   reg [3:0] i2c_cnt_ff;
   reg [7:0] spi_rx_ff, spi_tx_ff, spi_cmd_ff, i2c_rx_ff, i2c_tx_ff;
   reg [1:0] spi_left_ff, i2c_left_ff, i2c_src_ff;
   reg [23:0] res_ff;
   reg [7:0] nvm_byte_ff, op_code_ff;
   reg op_go_ff, i2c_opp_ff, ack_want_ff, stretch_pend_ff, nvm_rdy_ff;
   reg [9:0] busy_cnt_ff;

   wire cs_fall = cs_d_ff & ~cs_q;
   wire sclk_rise = ~sclk_d_ff & sclk_q;
   wire sclk_fall = sclk_d_ff & ~sclk_q;
   wire scl_rise = ~scl_d_ff & scl_q;
   wire scl_fall = scl_d_ff & ~scl_q;
   wire i2c_start = scl_q & scl_d_ff & sda_d_ff & ~sda_q;
   wire i2c_stop = scl_q & scl_d_ff & ~sda_d_ff & sda_q;
   wire [7:0] spi_byte = {spi_rx_ff[6:0], sdi_q};
   wire [7:0] i2c_byte = {i2c_rx_ff[6:0], sda_q};
   wire i2c_active = (i2c_st_ff != I_IDLE) && (i2c_st_ff != I_SKIP);

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cs_d_ff <= 1'b1;
         sclk_d_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         spi_st_ff <= S_CMD;
         i2c_st_ff <= I_IDLE;
         spi_cnt_ff <= 3'h0;
         i2c_cnt_ff <= 4'h0;
         spi_rx_ff <= 8'h00;
         spi_tx_ff <= 8'h00;
         spi_cmd_ff <= 8'h00;
         i2c_rx_ff <= 8'h00;
         i2c_tx_ff <= 8'hff;
         spi_left_ff <= 2'h0;
         i2c_left_ff <= 2'h0;
         i2c_src_ff <= `SSCP_SRC_NONE;
         res_ff <= 24'h000000;
         nvm_byte_ff <= 8'h00;
         op_code_ff <= 8'h00;
         op_go_ff <= 1'b0;
         i2c_opp_ff <= 1'b0;
         ack_want_ff <= 1'b0;
         stretch_pend_ff <= 1'b0;
         nvm_rdy_ff <= 1'b0;
         busy_cnt_ff <= 10'h000;
         nvm_req <= 1'b0;
         nvm_addr <= 8'h00;
         sdo <= 1'b0;
         sdo_oe_n <= 1'b1;
         scl_out <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         cs_d_ff <= cs_q;
         sclk_d_ff <= sclk_q;
         scl_d_ff <= scl_q;
         sda_d_ff <= sda_q;
         op_go_ff <= 1'b0;
         nvm_req <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         if (nvm_req) begin
            nvm_rdy_ff <= 1'b0;
            busy_cnt_ff <= 10'h000;
         end else if (nvm_done) begin
            nvm_rdy_ff <= 1'b1;
            nvm_byte_ff <= nvm_data;
         end else if (!nvm_rdy_ff) begin
            if (busy_cnt_ff >= NVM_BUSY_CYC[9:0] - 10'h001)
               nvm_rdy_ff <= 1'b1;
            else
               busy_cnt_ff <= busy_cnt_ff + 10'h001;
         end
         if (!sel_q || cs_q) begin
            spi_st_ff <= S_CMD;
            spi_cnt_ff <= 3'h0;
            sdo_oe_n <= 1'b1;
         end else if (cs_fall) begin
            spi_st_ff <= sclk_q ? S_CMD : S_DONE;
            spi_cnt_ff <= 3'h0;
            spi_tx_ff <= 8'h00;
            sdo <= 1'b0;
            sdo_oe_n <= 1'b0;
         end else if (sclk_rise) begin
            spi_rx_ff <= spi_byte;
            spi_cnt_ff <= spi_cnt_ff + 3'h1;
            if (spi_cnt_ff == 3'h7) begin
               case (spi_st_ff)
                  S_CMD: begin
                     spi_cmd_ff <= spi_byte;
                     spi_tx_ff <= `SSCP_ACK_BYTE;
                     spi_st_ff <= S_ACK;
                  end
                  S_ACK: begin
                     spi_tx_ff <= 8'h00;
                     spi_st_ff <= S_DONE;
                     case (cmd_class(spi_cmd_ff))
                        `SSCP_CL_OP: begin
                           op_go_ff <= 1'b1;
                           op_code_ff <= spi_cmd_ff;
                        end
                        `SSCP_CL_RES: begin
                           res_ff <= result_data;
                           spi_tx_ff <= result_data[23:16];
                           spi_left_ff <= 2'h2;
                           spi_st_ff <= S_DATA;
                        end
                        `SSCP_CL_STAT: begin
                           spi_tx_ff <= status_data;
                           spi_left_ff <= 2'h0;
                           spi_st_ff <= S_DATA;
                        end
                        `SSCP_CL_NVM: spi_st_ff <= S_ADDR;
                        default: spi_st_ff <= S_DONE;
                     endcase
                  end
                  S_DATA: begin
                     spi_left_ff <= spi_left_ff - 2'h1;
                     if (spi_left_ff == 2'h2)
                        spi_tx_ff <= res_ff[15:8];
                     else if (spi_left_ff == 2'h1)
                        spi_tx_ff <= res_ff[7:0];
                     else begin
                        spi_tx_ff <= 8'h00;
                        spi_st_ff <= S_DONE;
                     end
                  end
                  S_ADDR: begin
                     spi_tx_ff <= `SSCP_BUSY_BYTE;
                     if (nvm_addr_ok(spi_byte)) begin
                        nvm_req <= 1'b1;
                        nvm_addr <= spi_byte;
                        spi_st_ff <= S_POLL;
                     end else
                        spi_st_ff <= S_DONE;
                  end
                  S_POLL: begin
                     if (nvm_rdy_ff) begin
                        spi_tx_ff <= `SSCP_READY_BYTE;
                        spi_st_ff <= S_NVMD;
                     end else
                        spi_tx_ff <= `SSCP_BUSY_BYTE;
                  end
                  S_NVMD: begin
                     spi_tx_ff <= nvm_byte_ff;
                     spi_st_ff <= S_DONE;
                  end
                  default: spi_tx_ff <= 8'h00;
               endcase
            end
         end else if (sclk_fall)
            sdo <= spi_tx_ff[3'h7 - spi_cnt_ff];
         // i2c link, active with select low
         if (sel_q) begin
            i2c_st_ff <= I_IDLE;
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
            stretch_pend_ff <= 1'b0;
         end else if (i2c_start) begin
            i2c_st_ff <= I_ADDR;
            i2c_cnt_ff <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (i2c_stop) begin
            i2c_st_ff <= I_IDLE;
            sda_oe_n <= 1'b1;
         end else if (scl_rise && i2c_active) begin
            i2c_cnt_ff <= (i2c_cnt_ff == 4'h8) ? 4'h0 : i2c_cnt_ff + 4'h1;
            if (i2c_cnt_ff != 4'h8)
               i2c_rx_ff <= i2c_byte;
            if (i2c_cnt_ff == 4'h7) begin
               ack_want_ff <= 1'b1;
               case (i2c_st_ff)
                  I_ADDR: begin
                     if (i2c_byte[7:1] == `SSCP_SLAVE_ADDR) begin
                        if (i2c_byte[0]) begin
                           i2c_st_ff <= I_RD;
                           i2c_left_ff <= 2'h0;
                           i2c_tx_ff <= `SSCP_IDLE_BYTE;
                           if (i2c_src_ff == `SSCP_SRC_RES) begin
                              res_ff <= result_data;
                              i2c_tx_ff <= result_data[23:16];
                              i2c_left_ff <= 2'h2;
                           end else if (i2c_src_ff == `SSCP_SRC_STAT)
                              i2c_tx_ff <= status_data;
                           else if (i2c_src_ff == `SSCP_SRC_NVM)
                              i2c_tx_ff <= nvm_byte_ff;
                        end else
                           i2c_st_ff <= I_CMD;
                     end else begin
                        ack_want_ff <= 1'b0;
                        i2c_st_ff <= I_SKIP;
                     end
                  end
                  I_CMD: begin
                     i2c_st_ff <= I_WRX;
                     i2c_src_ff <= `SSCP_SRC_NONE;
                     case (cmd_class(i2c_byte))
                        `SSCP_CL_OP: begin
                           i2c_opp_ff <= 1'b1;
                           op_code_ff <= i2c_byte;
                        end
                        `SSCP_CL_RES: i2c_src_ff <= `SSCP_SRC_RES;
                        `SSCP_CL_STAT: i2c_src_ff <= `SSCP_SRC_STAT;
                        `SSCP_CL_NVM: i2c_st_ff <= I_MADDR;
                        default: i2c_src_ff <= `SSCP_SRC_NONE;
                     endcase
                  end
                  I_MADDR: begin
                     if (nvm_addr_ok(i2c_byte)) begin
                        nvm_req <= 1'b1;
                        nvm_addr <= i2c_byte;
                        stretch_pend_ff <= 1'b1;
                        i2c_src_ff <= `SSCP_SRC_NVM;
                        i2c_st_ff <= I_WRX;
                     end else begin
                        ack_want_ff <= 1'b0;
                        i2c_st_ff <= I_SKIP;
                     end
                  end
                  I_RD: ack_want_ff <= 1'b0;
                  default: ack_want_ff <= 1'b1;
               endcase
            end
            if (i2c_cnt_ff == 4'h8) begin
               ack_want_ff <= 1'b0;
               if (i2c_opp_ff) begin
                  i2c_opp_ff <= 1'b0;
                  op_go_ff <= 1'b1;
               end
               // own ack of the read address leaves the first byte in place
               if (i2c_st_ff == I_RD && !ack_want_ff) begin
                  if (sda_q)
                     i2c_st_ff <= I_SKIP;
                  else begin
                     i2c_left_ff <= i2c_left_ff - {1'b0, i2c_left_ff != 2'h0};
                     if (i2c_left_ff == 2'h2)
                        i2c_tx_ff <= res_ff[15:8];
                     else if (i2c_left_ff == 2'h1)
                        i2c_tx_ff <= res_ff[7:0];
                     else
                        i2c_tx_ff <= `SSCP_IDLE_BYTE;
                  end
               end
            end
         end else if (scl_fall) begin
            if (i2c_cnt_ff == 4'h8)
               sda_oe_n <= ~ack_want_ff;
            else if (i2c_st_ff == I_RD)
               sda_oe_n <= i2c_tx_ff[3'h7 - i2c_cnt_ff[2:0]];
            else
               sda_oe_n <= 1'b1;
            if (i2c_cnt_ff == 4'h0 && stretch_pend_ff) begin
               scl_oe_n <= 1'b0;
               stretch_pend_ff <= 1'b0;
            end
         end
         if (!scl_oe_n && nvm_rdy_ff && !nvm_req)
            scl_oe_n <= 1'b1;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_valid <= 1'b0;
         cmd_code <= 8'h00;
         go_shutdown <= 1'b0;
         go_idle <= 1'b0;
         start_measure <= 1'b0;
         measure_setting <= 2'h0;
      end else begin
         cmd_valid <= op_go_ff;
         go_shutdown <= op_go_ff && (op_code_ff == `SSCP_CMD_RESET);
         go_idle <= op_go_ff && (op_code_ff == `SSCP_CMD_IDLE);
         start_measure <= op_go_ff && (op_code_ff[7:3] == `SSCP_CMD_MEAS1 >> 3);
         if (op_go_ff) begin
            cmd_code <= op_code_ff;
            measure_setting <= op_code_ff[2:1];
         end
      end
   end
endmodule // sscp_port

// ===== sscp_defines.vh
// constants for the sensor serial command port
`ifndef SSCP_DEFINES_VH
`define SSCP_DEFINES_VH
`define SSCP_CMD_RESET 8'h72
`define SSCP_CMD_IDLE 8'h94
`define SSCP_CMD_MEAS1 8'ha0
`define SSCP_CMD_MEAS2 8'ha2
`define SSCP_CMD_MEAS3 8'ha4
`define SSCP_CMD_MEAS4 8'ha6
`define SSCP_CMD_PRESS 8'hc0
`define SSCP_CMD_STATUS 8'h80
`define SSCP_CMD_NVM 8'hd6
`define SSCP_NVM_ADDR_A 8'h75
`define SSCP_NVM_ADDR_B 8'h76
`define SSCP_SLAVE_ADDR 7'h65
`define SSCP_ACK_BYTE 8'h00
`define SSCP_BUSY_BYTE 8'h00
`define SSCP_READY_BYTE 8'h01
`define SSCP_IDLE_BYTE 8'hff
`define SSCP_CLK_NS 50
`define SSCP_NVM_BUSY_NS 25000
`define SSCP_NVM_BUSY_CYC (`SSCP_NVM_BUSY_NS / `SSCP_CLK_NS)
`define SSCP_CL_OP 3'h0
`define SSCP_CL_RES 3'h1
`define SSCP_CL_STAT 3'h2
`define SSCP_CL_NVM 3'h3
`define SSCP_CL_OTHER 3'h4
`define SSCP_SRC_NONE 2'h0
`define SSCP_SRC_RES 2'h1
`define SSCP_SRC_STAT 2'h2
`define SSCP_SRC_NVM 2'h3
`endif

// ===== sscp_sync.v
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module sscp_sync #(
   parameter W = 6,
   parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
   input wire mclk,
   input wire reset_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_ff;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule // sscp_sync

// ===== sscp_port_sva.sv
// concurrent checks on the serial command port pins and core strobes
`timescale 1ns/1ns
module sscp_port_sva #(
   parameter int NVM_BUSY_CYC = 500
) (
   input wire mclk,
   input wire reset_n,
   input wire iface_select,
   input wire chip_select_low,
   input wire sdo_oe_n,
   input wire scl_oe_n,
   input wire sda_oe_n,
   input wire scl_out,
   input wire sda_out,
   input wire nvm_done,
   input wire cmd_valid,
   input wire [7:0] cmd_code,
   input wire go_shutdown,
   input wire go_idle,
   input wire start_measure,
   input wire [1:0] measure_setting,
   input wire nvm_req,
   input wire [7:0] nvm_addr
);
   localparam int STRETCH_MAX = NVM_BUSY_CYC + 8;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence stretch_on_s;
      $fell(scl_oe_n);
   endsequence
   sequence stretch_off_s;
      ##[1:STRETCH_MAX] scl_oe_n;
   endsequence
   spi_mode_a: assert property (iface_select [*5] |-> scl_oe_n && sda_oe_n)
      else $error("i2c pins pulled in spi mode");
   i2c_mode_a: assert property (!iface_select [*5] |-> sdo_oe_n)
      else $error("sdo driven in i2c mode");
   desel_a: assert property (chip_select_low [*5] |-> sdo_oe_n)
      else $error("sdo driven while deselected");
   cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command strobe longer than one cycle");
   cmd_code_a: assert property (cmd_valid |->
      cmd_code inside {8'h72, 8'h94, 8'ha0, 8'ha2, 8'ha4, 8'ha6})
      else $error("strobe with unknown command");
   state_cmd_a: assert property (cmd_valid |->
      go_shutdown == (cmd_code == 8'h72) && go_idle == (cmd_code == 8'h94))
      else $error("shutdown or idle decode wrong");
   measure_a: assert property (cmd_valid && cmd_code[7:4] == 4'ha |->
      start_measure && measure_setting == cmd_code[2:1])
      else $error("measure setting wrong");
   decode_only_a: assert property ((go_shutdown || go_idle || start_measure) |-> cmd_valid)
      else $error("decode pulse without command");
   nvm_addr_a: assert property (nvm_req |-> nvm_addr inside {8'h75, 8'h76})
      else $error("memory request with bad address");
   stretch_len_a: assert property (stretch_on_s |-> stretch_off_s)
      else $error("clock stretch too long");
   stretch_rel_a: assert property (nvm_done && !scl_oe_n |-> ##[1:6] scl_oe_n)
      else $error("clock not released after data ready");
   od_low_a: assert property (!scl_out && !sda_out)
      else $error("open-drain output level not low");
endmodule // sscp_port_sva

// ===== sscp_host.sv
// host model: spi mode 3 master and i2c master on pulled-up wires
`timescale 1ns/1ns
module sscp_host (
   output logic sclk,
   output logic chip_select_low,
   output logic sdi,
   input wire sdo,
   output wire scl_in,
   input wire scl_oe_n,
   output wire sda_in,
   input wire sda_oe_n
);
   logic scl_h = 1'b1;
   logic sda_h = 1'b1;
   assign scl_in = scl_h & scl_oe_n;
   assign sda_in = sda_h & sda_oe_n;
   initial begin
      sclk = 1'b1;
      chip_select_low = 1'b1;
      sdi = 1'b0;
   end
   task automatic spi_open(input logic clk_high);
      sclk = clk_high;
      #150 chip_select_low = 1'b0;
      #250 sclk = 1'b1;
   endtask
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = tx[i];
         #200 sclk = 1'b1;
         #190 rx[i] = sdo;
         #10;
      end
   endtask
   task automatic spi_close;
      #200 chip_select_low = 1'b1;
      sdi = ~sdi;
      #1000;
   endtask
   task automatic i2c_start;
      sda_h = 1'b1;
      #100 scl_h = 1'b1;
      wait (scl_in === 1'b1);
      #200 sda_h = 1'b0;
      #200 scl_h = 1'b0;
      #100;
   endtask
   task automatic i2c_stop;
      sda_h = 1'b0;
      #100 scl_h = 1'b1;
      #200 sda_h = 1'b1;
      #400;
   endtask
   task automatic i2c_bit(input logic b, output logic r);
      sda_h = b;
      #100 scl_h = 1'b1;
      wait (scl_in === 1'b1);
      #190 r = sda_in;
      #10 scl_h = 1'b0;
      #100;
   endtask
   task automatic i2c_byte(input logic [7:0] tx, input logic ack_out,
                           output logic [7:0] rx, output logic ack_in);
      for (int i = 7; i >= 0; i--)
         i2c_bit(tx[i], rx[i]);
      i2c_bit(ack_out, ack_in);
   endtask
endmodule // sscp_host

// ===== sscp_port_tb.sv
// self-checking testbench for the serial command port
`timescale 1ns/1ns
module sscp_port_tb;
   localparam int NVM_BUSY_CYC = 20;
   localparam int CYC_MAX = 20000;
   localparam logic [23:0] RES = 24'h5a3c96;
   localparam logic [7:0] STAT = 8'ha5;
   logic mclk, reset_n, iface_select, nvm_done;
   logic [23:0] result_data;
   logic [7:0] status_data, nvm_data, last_code;
   logic [2:0] last_go;
   logic [1:0] last_set;
   wire sclk, chip_select_low, sdi, sdo, sdo_oe_n, scl_in, scl_out, scl_oe_n;
   wire sda_in, sda_out, sda_oe_n, cmd_valid, go_shutdown, go_idle, start_measure, nvm_req;
   wire [7:0] cmd_code, nvm_addr;
   wire [1:0] measure_setting;
   int fail_count = 0, comparisons = 0, op_cnt = 0, req_cnt = 0, hold_cnt = 0;
   int cyc = 0, nvm_wait = 0;
   logic [7:0] codes [6] = '{8'h72, 8'h94, 8'ha0, 8'ha2, 8'ha4, 8'ha6};
   sscp_port #(.NVM_BUSY_CYC(NVM_BUSY_CYC)) i_sscp_port (.mclk, .reset_n, .iface_select,
      .chip_select_low, .sclk, .sdi, .sdo, .sdo_oe_n, .scl_in, .scl_out, .scl_oe_n, .sda_in,
      .sda_out, .sda_oe_n, .result_data, .status_data, .nvm_done, .nvm_data, .cmd_valid,
      .cmd_code, .go_shutdown, .go_idle, .start_measure, .measure_setting, .nvm_req, .nvm_addr);
   sscp_host i_sscp_host (.sclk, .chip_select_low, .sdi, .sdo, .scl_in, .scl_oe_n, .sda_in,
      .sda_oe_n);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (cmd_valid === 1'b1) begin
         op_cnt++;
         last_code = cmd_code;
         last_go = {go_shutdown, go_idle, start_measure};
         last_set = measure_setting;
      end
      if (nvm_req === 1'b1)
         req_cnt++;
      if (scl_oe_n === 1'b0)
         hold_cnt++;
      cyc++;
      if (cyc == CYC_MAX) begin
         fail_count++;
         stop_test;
      end
   end
   // core memory answers 16 cycles after a request, inside the clock stretch
   always @(negedge mclk) begin
      nvm_done <= (nvm_req !== 1'b1 && nvm_wait == 1);
      if (nvm_req === 1'b1) begin
         nvm_wait <= 16;
         nvm_data <= nvm_addr ^ 8'h5f;
      end else if (nvm_wait > 0)
         nvm_wait <= nvm_wait - 1;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic spi_pre(input logic [7:0] code);
      logic [7:0] rx;
      i_sscp_host.spi_open(1'b1);
      i_sscp_host.spi_byte(code, rx);
      i_sscp_host.spi_byte(8'h00, rx);
      chk(rx, 8'h00);
   endtask
   task automatic i2c_w(input logic [7:0] b, input logic exp_ack);
      logic [7:0] rx;
      logic a;
      i_sscp_host.i2c_byte(b, 1'b1, rx, a);
      chk(a, exp_ack);
   endtask
   task automatic t_ops(input logic spi);
      int n;
      for (int k = 0; k < 6; k++) begin
         n = op_cnt;
         if (spi) begin
            spi_pre(codes[k]);
            i_sscp_host.spi_close;
         end else begin
            i_sscp_host.i2c_start;
            i2c_w(8'hca, 1'b0);
            i2c_w(codes[k], 1'b0);
            i_sscp_host.i2c_stop;
         end
         chk(op_cnt - n, 1);
         chk(last_code, codes[k]);
         chk(last_go, {codes[k] == 8'h72, codes[k] == 8'h94, codes[k][7:4] == 4'ha});
         if (codes[k][7:4] == 4'ha)
            chk(last_set, codes[k][2:1]);
      end
   endtask
   task automatic t_spi_result;
      logic [7:0] b0, b1, b2;
      spi_pre(8'hc0);
      i_sscp_host.spi_byte(8'h00, b0);
      i_sscp_host.spi_byte(8'h00, b1);
      i_sscp_host.spi_byte(8'h00, b2);
      i_sscp_host.spi_close;
      chk({b0, b1, b2}, RES);
      spi_pre(8'h80);
      i_sscp_host.spi_byte(8'h00, b0);
      i_sscp_host.spi_close;
      chk(b0, STAT);
   endtask
   task automatic t_spi_nvm;
      logic [7:0] rx;
      int n;
      n = req_cnt;
      spi_pre(8'hd6);
      i_sscp_host.spi_byte(8'h75, rx);
      rx = 8'h00;
      for (int k = 0; k < 40 && rx === 8'h00; k++)
         i_sscp_host.spi_byte(8'h00, rx);
      chk(rx, 8'h01);
      i_sscp_host.spi_byte(8'h00, rx);
      i_sscp_host.spi_close;
      chk(rx, 8'h75 ^ 8'h5f);
      chk(req_cnt - n, 1);
   endtask
   task automatic t_spi_clk_low;
      logic [7:0] rx;
      int n;
      n = op_cnt;
      i_sscp_host.spi_open(1'b0);
      i_sscp_host.spi_byte(8'h94, rx);
      i_sscp_host.spi_byte(8'h00, rx);
      i_sscp_host.spi_close;
      chk(op_cnt - n, 0);
   endtask
   task automatic t_i2c_read;
      logic [7:0] b0, b1, b2;
      logic a;
      i_sscp_host.i2c_start;
      i2c_w(8'hca, 1'b0);
      i2c_w(8'hc0, 1'b0);
      i_sscp_host.i2c_start;
      i2c_w(8'hcb, 1'b0);
      i_sscp_host.i2c_byte(8'hff, 1'b0, b0, a);
      i_sscp_host.i2c_byte(8'hff, 1'b0, b1, a);
      i_sscp_host.i2c_byte(8'hff, 1'b1, b2, a);
      i_sscp_host.i2c_stop;
      chk({b0, b1, b2}, RES);
      i_sscp_host.i2c_start;
      i2c_w(8'hca, 1'b0);
      i2c_w(8'h80, 1'b0);
      i_sscp_host.i2c_start;
      i2c_w(8'hcb, 1'b0);
      i_sscp_host.i2c_byte(8'hff, 1'b0, b0, a);
      i_sscp_host.i2c_byte(8'hff, 1'b1, b1, a);
      i_sscp_host.i2c_stop;
      chk(b0, STAT);
      chk(b1, 8'hff);
      i_sscp_host.i2c_start;
      i2c_w(8'hca, 1'b0);
      i2c_w(8'hc0, 1'b0);
      i_sscp_host.i2c_start;
      i2c_w(8'hcb, 1'b0);
      i_sscp_host.i2c_byte(8'hff, 1'b1, b0, a);
      i_sscp_host.i2c_byte(8'hff, 1'b1, b1, a);
      i_sscp_host.i2c_stop;
      chk(b0, RES[23:16]);
      chk(b1, 8'hff);
   endtask
   task automatic t_i2c_misc;
      logic [7:0] b0;
      logic a;
      int n, h;
      n = op_cnt;
      i_sscp_host.i2c_start;
      i2c_w(8'h88, 1'b1);
      i2c_w(8'h94, 1'b1);
      i_sscp_host.i2c_stop;
      chk(op_cnt - n, 0);
      h = hold_cnt;
      i_sscp_host.i2c_start;
      i2c_w(8'hca, 1'b0);
      i2c_w(8'hd6, 1'b0);
      i2c_w(8'h76, 1'b0);
      i_sscp_host.i2c_start;
      i2c_w(8'hcb, 1'b0);
      i_sscp_host.i2c_byte(8'hff, 1'b1, b0, a);
      i_sscp_host.i2c_stop;
      chk(b0, 8'h76 ^ 8'h5f);
      chk(hold_cnt > h, 1'b1);
   endtask
   initial begin
      reset_n = 1'b0;
      iface_select = 1'b1;
      result_data = RES;
      status_data = STAT;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      repeat (8) @(negedge mclk);
      t_ops(1'b1);
      t_spi_result;
      t_spi_nvm;
      t_spi_clk_low;
      @(negedge mclk);
      iface_select = 1'b0;
      repeat (8) @(negedge mclk);
      t_ops(1'b0);
      t_i2c_read;
      t_i2c_misc;
      stop_test;
   end
endmodule // sscp_port_tb
bind sscp_port sscp_port_sva #(.NVM_BUSY_CYC(NVM_BUSY_CYC)) i_sscp_port_sva (.*);
